// >>> hw/chan_cfg.svh
// constants shared by the current output channel and its com unit end
// Behaviour
// (R1) rate limit in percent per second, zero disables
// (R2) simulation mode outputs stored percentage, -25..125
// (R3) flag sets invalid status on simulation value
// (R4) error with substitute mode outputs substitute value
// (R5) substitute value always carries invalid status
// (R6) twelve bit code spans zero to 25 mA
// (R7) 4..20 mA equals 2500 steps of 0.04%
// (R8) one conversion every 50 ms
// (R9) word exchanged every 6.5 ms, independent of conversion
// (R10) fieldbus master writes words into com unit memory
// (R11) process data is unsigned 0 to 65535
// (R12) one 16-bit word, low four bits status
// (R13) status bits dropped when scaling is nonstandard
// (R14) bit 1 is invalid flag, 1 invalid
// (R15) bits 15..4 carry 12-bit value, no inputs
// (R16) exactly one output channel
// (R17) normal passes live value, simulation passes stored
// (R18) error strategy: current, substitute or last valid
// (R19) output off 500 ms after three failed exchanges
// (R20) 10000 points 0 percent, 50000 points 100 percent
// (R21) each word loads target code from bits 15..4
// (R22) limiter steps toward target, never overshoots
`ifndef CHAN_CFG_SVH
`define CHAN_CFG_SVH
// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ 25
`define EXCH_US 6500
`define CONV_US 50000
`define WDOG_US 500000
`define FAIL_LIMIT 2'h3
// ****************************************************************
// word layout and scaling
// ****************************************************************
`define INVALID_BIT 1
`define VALUE_LSB 4
`define VALUE_MSB 15
`define ZERO_PCT_CODE 13'sh0271
`define PCT_MIN 13'sh1D8F
`define PCT_MAX 13'sh0C35
`define RATE_NUM 4'h5
`define RATE_SHIFT 2
// ****************************************************************
// com unit register map
// ****************************************************************
`define REG_OUT_WORD 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define CTRL_ENABLE 0
`define CTRL_BAD_PARITY 1
`define STATUS_ACK 16
`endif

// >>> hw/chan_pkg.sv
// types used by the current output channel and its bench
package chan_pkg;
	typedef logic [11:0] dac_code_t;
	typedef logic signed [12:0] pct_t;
	typedef enum logic [1:0] {ERR_CURRENT, ERR_SUBST, ERR_LAST} err_mode_e;
endpackage

// >>> hw/chan_link_if.sv
// link between com unit and current output module
`timescale 1ns/1ns
interface chan_link_if;
	logic word_valid;
	logic [15:0] word;
	logic parity;
	logic ack;
	modport dev (input word_valid, input word, input parity, output ack);
	modport com (output word_valid, output word, output parity, input ack);
endinterface

// >>> hw/current_output_channel.sv
// device end: unpacks output word, selects mode, rate limits, drives converter
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "chan_cfg.svh"
module current_output_channel
#(
	parameter int unsigned EXCH_CYC = `EXCH_US * `CLK_MHZ,
	parameter int unsigned SLOT_CYC = EXCH_CYC + EXCH_CYC / 2,
	parameter int unsigned CONV_CYC = `CONV_US * `CLK_MHZ,
	parameter int unsigned WDOG_CYC = `WDOG_US * `CLK_MHZ
)
(
	input wire logic hclk,
	input wire logic hresetn,
	chan_link_if.dev link,
	input wire logic sim_mode,
	input chan_pkg::err_mode_e err_mode,
	input wire logic sim_invalid_cfg,
	input chan_pkg::pct_t sim_pct,
	input chan_pkg::pct_t subst_pct,
	input wire logic [7:0] rate_pct,
	input wire logic scale_std,
	input wire logic line_fault,
	output chan_pkg::dac_code_t dac_code,
	output logic dac_load,
	output logic status_invalid,
	output logic out_off
);
	localparam int CW = 24;
	logic lf_s1_q;
	logic lf_s2_q;
	logic ack_q;
	logic [CW-1:0] slot_cnt_q;
	logic [1:0] fail_cnt_q;
	logic [CW-1:0] wd_cnt_q;
	logic out_off_q;
	logic [CW-1:0] conv_cnt_q;
	chan_pkg::dac_code_t live_code_q;
	logic word_inv_q;
	chan_pkg::dac_code_t last_valid_q;
	chan_pkg::dac_code_t dac_code_q;
	logic dac_load_q;
	logic status_invalid_q;
	logic good_word;
	logic slot_timeout;
	logic fail_event;
	logic conv_tick;
	logic fault;
	chan_pkg::dac_code_t tgt;
	logic tgt_inv;
	chan_pkg::dac_code_t step;
	logic [11:0] rate_scaled;

	// percentage in 0.04% units to converter code, clamped to -25..125 %
	function automatic chan_pkg::dac_code_t pct_code(input chan_pkg::pct_t p);
		chan_pkg::pct_t c;
		chan_pkg::pct_t s;
		c = p;
		if (c < `PCT_MIN)
			c = `PCT_MIN;
		if (c > `PCT_MAX)
			c = `PCT_MAX;
		s = c + `ZERO_PCT_CODE;
		return s[11:0];
	endfunction

	// ****************************************************************
	// link intake
	// ****************************************************************
	// a word counts only when its even parity checks
	assign good_word = link.word_valid && (link.parity == ^link.word);
	assign slot_timeout = (slot_cnt_q == CW'(SLOT_CYC - 1));
	assign fail_event = (link.word_valid && !good_word) || slot_timeout;

	// line fault pin through two flops
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lf_s1_q <= 1'b0;
			lf_s2_q <= 1'b0;
		end
		else
		begin
			lf_s1_q <= line_fault;
			lf_s2_q <= lf_s1_q;
		end
	end

	// unpack value and invalid flag of each good word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			live_code_q <= 12'h000;
			word_inv_q <= 1'b0;
		end
		else if (good_word)
		begin
			live_code_q <= link.word[`VALUE_MSB:`VALUE_LSB]; // [R21] [R15] [R12] [R20]
			word_inv_q <= scale_std ? link.word[`INVALID_BIT] : 1'b0; // [R14] [R13]
		end
	end

	// acknowledge pulse one cycle after a good word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ack_q <= 1'b0;
		else
			ack_q <= good_word; // [R9]
	end

	assign link.ack = ack_q;

	// ****************************************************************
	// exchange watchdog
	// ****************************************************************
	// slot timer restarts on every word and on expiry, expires after one and a half exchange periods without a word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			slot_cnt_q <= '0;
		else if (link.word_valid || slot_timeout)
			slot_cnt_q <= '0;
		else
			slot_cnt_q <= slot_cnt_q + 1'b1; // [R9]
	end

	// consecutive failures, saturating
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			fail_cnt_q <= 2'h0;
		else if (good_word)
			fail_cnt_q <= 2'h0;
		else if (fail_event && fail_cnt_q != `FAIL_LIMIT)
			fail_cnt_q <= fail_cnt_q + 2'h1; // [R19]
	end

	// switch off once failures have persisted for the watchdog time
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wd_cnt_q <= '0;
			out_off_q <= 1'b0;
		end
		else if (good_word)
		begin
			wd_cnt_q <= '0;
			out_off_q <= 1'b0;
		end
		else if (fail_cnt_q == `FAIL_LIMIT && !out_off_q)
		begin
			if (wd_cnt_q == CW'(WDOG_CYC - 1))
				out_off_q <= 1'b1; // [R19]
			else
				wd_cnt_q <= wd_cnt_q + 1'b1;
		end
	end

	// ****************************************************************
	// mode and error selection
	// ****************************************************************
	assign fault = word_inv_q || lf_s2_q;

	// remember last value seen without a fault
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			last_valid_q <= 12'h000;
		else if (!fault)
			last_valid_q <= live_code_q; // [R18]
	end

	// target code and its status
	always_comb
	begin
		tgt = live_code_q; // [R17]
		tgt_inv = fault;
		if (sim_mode)
		begin
			tgt = pct_code(sim_pct); // [R2] [R17]
			tgt_inv = sim_invalid_cfg; // [R3]
		end
		else if (fault)
		begin
			unique case (err_mode)
				chan_pkg::ERR_CURRENT: tgt = live_code_q; // [R18]
				chan_pkg::ERR_SUBST:
				begin
					tgt = pct_code(subst_pct); // [R4] [R18]
					tgt_inv = 1'b1; // [R5]
				end
				chan_pkg::ERR_LAST: tgt = last_valid_q; // [R18]
				default: tgt = live_code_q;
			endcase
		end
	end

	// ****************************************************************
	// conversion and rate limiter
	// ****************************************************************
	assign conv_tick = (conv_cnt_q == CW'(CONV_CYC - 1));

	// one converter update per conversion period
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			conv_cnt_q <= '0;
		else if (conv_tick)
			conv_cnt_q <= '0;
		else
			conv_cnt_q <= conv_cnt_q + 1'b1; // [R8]
	end

	// percent per second to codes per 50 ms, at least one code
	assign rate_scaled = (12'(rate_pct) * 12'(`RATE_NUM)) >> `RATE_SHIFT; // [R1] [R7]
	assign step = (rate_scaled == 12'h000) ? 12'h001 : rate_scaled;

	// converter code moves toward target without overshoot
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dac_code_q <= 12'h000;
		else if (conv_tick)
		begin
			if (out_off_q)
				dac_code_q <= 12'h000; // [R19]
			else if (rate_pct == 8'h00)
				dac_code_q <= tgt; // [R1]
			else if (tgt > dac_code_q)
				dac_code_q <= (tgt - dac_code_q > step) ? dac_code_q + step : tgt; // [R22]
			else if (tgt < dac_code_q)
				dac_code_q <= (dac_code_q - tgt > step) ? dac_code_q - step : tgt; // [R22]
		end
	end

	// load strobe follows each conversion, status follows the target every cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dac_load_q <= 1'b0;
			status_invalid_q <= 1'b0;
		end
		else
		begin
			dac_load_q <= conv_tick; // [R6] [R16]
			status_invalid_q <= tgt_inv;
		end
	end

	assign dac_code = dac_code_q;
	assign dac_load = dac_load_q;
	assign status_invalid = status_invalid_q;
	assign out_off = out_off_q;
endmodule

// >>> hw/com_unit_end.sv
// com unit end: holds the master's output word and sends it every exchange period
`timescale 1ns/1ns
`include "chan_cfg.svh"
module com_unit_end
#(
	parameter int unsigned EXCH_CYC = `EXCH_US * `CLK_MHZ
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	chan_link_if.com link
);
	localparam int CW = 24;
	logic [15:0] out_word_q;
	logic [1:0] ctrl_q;
	logic [15:0] xfer_cnt_q;
	logic ack_seen_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic [CW-1:0] per_cnt_q;
	logic valid_q;
	logic [15:0] word_q;
	logic parity_q;
	logic addr_ok;
	logic send;
	logic [31:0] rd_val;

	// ****************************************************************
	// ahb-lite slave, zero wait states
	// ****************************************************************
	assign addr_ok = hsel && htrans[1] && hready && hsize == 3'h2;

	// read mux, unmapped reads return zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		unique case (haddr[7:0])
			`REG_OUT_WORD: rd_val = {16'h0000, out_word_q};
			`REG_CTRL: rd_val = {30'h0000_0000, ctrl_q};
			`REG_STATUS: rd_val = {15'h0000, ack_seen_q, xfer_cnt_q};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b0;
		end
		else
		begin
			hreadyout_q <= 1'b1;
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok)
				wr_addr_q <= haddr[7:0];
			if (addr_ok && !hwrite)
				hrdata_q <= rd_val;
		end
	end

	// register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_word_q <= 16'h0000;
			ctrl_q <= 2'h0;
		end
		else if (wr_pend_q)
		begin
			if (wr_addr_q == `REG_OUT_WORD)
				out_word_q <= hwdata[15:0]; // [R10] [R11]
			if (wr_addr_q == `REG_CTRL)
				ctrl_q <= hwdata[1:0];
		end
	end

	// ****************************************************************
	// periodic exchange
	// ****************************************************************
	assign send = ctrl_q[`CTRL_ENABLE] && per_cnt_q == CW'(EXCH_CYC - 1);

	// exchange period counter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			per_cnt_q <= '0;
		else if (!ctrl_q[`CTRL_ENABLE] || send)
			per_cnt_q <= '0;
		else
			per_cnt_q <= per_cnt_q + 1'b1; // [R9]
	end

	// word out with even parity, optionally corrupted
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			valid_q <= 1'b0;
			word_q <= 16'h0000;
			parity_q <= 1'b0;
		end
		else
		begin
			valid_q <= send; // [R9]
			if (send)
			begin
				word_q <= out_word_q; // [R12] [R14] [R15]
				parity_q <= (^out_word_q) ^ ctrl_q[`CTRL_BAD_PARITY];
			end
		end
	end

	// acknowledge tracking, set wins over clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ack_seen_q <= 1'b0;
			xfer_cnt_q <= 16'h0000;
		end
		else
		begin
			if (link.ack)
			begin
				ack_seen_q <= 1'b1;
				xfer_cnt_q <= xfer_cnt_q + 16'h0001;
			end
			else if (send)
				ack_seen_q <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;
	assign link.word_valid = valid_q;
	assign link.word = word_q;
	assign link.parity = parity_q;
endmodule

// >>> bench/chan_link_sva.sv
// link checker between the com unit end and the current output channel
`timescale 1ns/1ns
module chan_link_sva
#(
	parameter int unsigned EXCH_CYC = 50
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic word_valid,
	input wire logic [15:0] word,
	input wire logic parity,
	input wire logic ack
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	int unsigned gap_q;
	logic seen_q;
	// ********
	// helpers
	// ********
	// cycles since the last word, and first word seen
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gap_q <= 32'h0;
			seen_q <= 1'b0;
		end
		else
		begin
			gap_q <= word_valid ? 32'h0 : gap_q + 32'h1;
			seen_q <= seen_q | word_valid;
		end
	end
	sequence good_word;
		word_valid && parity == ^word;
	endsequence
	sequence bad_word;
		word_valid && parity != ^word;
	endsequence
	// ********
	// link properties
	// ********
	good_ack_a: assert property (good_word |=> ack ##1 !ack)
		else $error("good word without single ack");
	bad_noack_a: assert property (bad_word |=> !ack)
		else $error("bad word acknowledged");
	ack_cause_a: assert property (ack |-> $past(word_valid))
		else $error("ack without word");
	ack_single_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	valid_single_a: assert property (word_valid |=> !word_valid)
		else $error("word valid longer than one cycle");
	exch_gap_a: assert property (word_valid && seen_q |-> gap_q == EXCH_CYC - 1)
		else $error("exchange period wrong");
	word_hold_a: assert property (!word_valid |-> $stable(word))
		else $error("word changed between sends");
	parity_hold_a: assert property (!word_valid |-> $stable(parity))
		else $error("parity changed between sends");
	bad_seen_c: cover property (bad_word);
endmodule

// >>> bench/current_output_channel_logic_bench.sv
// self-checking bench for the current output channel and the com unit end that feeds it
`timescale 1ns/1ns
module current_output_channel_logic_bench;
	localparam int unsigned EXCH = 50;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic sim_mode = 1'b0;
	chan_pkg::err_mode_e err_mode = chan_pkg::ERR_CURRENT;
	logic sim_invalid_cfg = 1'b0;
	chan_pkg::pct_t sim_pct = 13'h0;
	chan_pkg::pct_t subst_pct = 13'h0;
	logic [7:0] rate_pct = 8'h0;
	logic scale_std = 1'b0;
	logic line_fault = 1'b0;
	chan_pkg::dac_code_t dac_code;
	logic dac_load;
	logic status_invalid;
	logic out_off;
	int errors = 0;
	int n_tests = 0;
	logic [15:0] lfsr_q = 16'h0024;
	chan_link_if link();
	com_unit_end #(.EXCH_CYC(EXCH)) com_unit_end_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link(link));
	current_output_channel #(.EXCH_CYC(EXCH), .SLOT_CYC(200), .CONV_CYC(20), .WDOG_CYC(100))
		current_output_channel_i (.hclk(hclk), .hresetn(hresetn), .link(link),
		.sim_mode(sim_mode), .err_mode(err_mode), .sim_invalid_cfg(sim_invalid_cfg),
		.sim_pct(sim_pct), .subst_pct(subst_pct), .rate_pct(rate_pct), .scale_std(scale_std),
		.line_fault(line_fault), .dac_code(dac_code), .dac_load(dac_load),
		.status_invalid(status_invalid), .out_off(out_off));
	chan_link_sva #(.EXCH_CYC(EXCH)) chan_link_sva_i (.hclk(hclk), .hresetn(hresetn),
		.word_valid(link.word_valid), .word(link.word), .parity(link.parity), .ack(link.ack));
	// ********
	// helpers
	// ********
	function automatic logic [15:0] rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q;
	endfunction
	// percent in 0.04 steps to converter code, clamped to -25..125
	function automatic int pct(input int p);
		return p < -625 ? 0 : p > 3125 ? 3750 : p + 625;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// one single word transfer, entered just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic acks(input int n);
		repeat (n) do @(negedge hclk); while (link.ack !== 1'b1);
	endtask
	task automatic loads(input int n);
		repeat (n) do @(negedge hclk); while (dac_load !== 1'b1);
	endtask
	task automatic summarize();
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ********
	// clock, timeout and scenarios
	// ********
	initial
	begin
		forever #20 hclk = ~hclk;
	end
	initial
	begin
		repeat (20000) @(posedge hclk);
		errors++;
		summarize();
	end
	initial
	begin
		logic [31:0] q;
		logic [15:0] w;
		logic [15:0] wp;
		logic [15:0] r;
		logic [11:0] last;
		int sp;
		int bp;
		int c;
		int e;
		int em;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		bus(1'b1, 8'h04, 32'h1, q);
		wp = 16'h0;
		last = 12'h0;
		for (int i = 0; i < 12; i++)
		begin
			@(posedge hclk);
			w = rnd();
			r = rnd();
			em = i % 3;
			sp = int'(rnd() % 16'hFA0) - 800;
			bp = int'(rnd() % 16'hFA0) - 800;
			sim_mode <= (i % 4 == 3);
			scale_std <= r[0];
			sim_invalid_cfg <= r[1];
			err_mode <= chan_pkg::err_mode_e'(em);
			sim_pct <= chan_pkg::pct_t'(sp);
			subst_pct <= chan_pkg::pct_t'(bp);
			acks(2);
			@(posedge hclk);
			line_fault <= (i % 5 == 4); // after the resend, so fault states change one at a time
			bus(1'b1, 8'h00, {16'h0, w}, q);
			if (!(r[0] && wp[1]))
				last = wp[15:4];
			e = (r[0] && w[1]) || i % 5 == 4;
			c = i % 4 == 3 ? pct(sp) : !e || em == 0 ? w[15:4] : em == 1 ? pct(bp) : last;
			if (!e)
				last = w[15:4];
			acks(2);
			loads(2);
			chk("code", c, dac_code);
			chk("invalid", i % 4 == 3 ? r[1] : e, status_invalid);
			wp = w;
		end
		@(posedge hclk);
		bus(1'b0, 8'h00, 32'h0, q);
		chk("out word", {16'h0, wp}, q);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk("unmapped", 32'h0, q);
		hsize <= 3'h1;
		bus(1'b1, 8'h00, 32'hFFFF, q);
		hsize <= 3'h2;
		bus(1'b0, 8'h00, 32'h0, q);
		chk("narrow write", {16'h0, wp}, q);
		sim_mode <= 1'b1;
		sim_pct <= 13'h0;
		line_fault <= 1'b0;
		bus(1'b1, 8'h00, 32'h2880, q);
		acks(2);
		loads(2);
		chk("code", 625, dac_code);
		@(posedge hclk);
		sim_mode <= 1'b0;
		rate_pct <= 8'h04;
		c = 625;
		repeat (6)
		begin
			loads(1);
			c = c + (648 - c < 4 * 25 / 20 ? 648 - c : 4 * 25 / 20);
			chk("limited code", c, dac_code);
		end
		@(posedge hclk);
		rate_pct <= 8'h0;
		bus(1'b1, 8'h04, 32'h3, q);
		repeat (3) do @(negedge hclk); while (link.word_valid !== 1'b1 || link.parity === ^link.word);
		repeat (90) @(negedge hclk);
		chk("off early", 32'h0, out_off);
		repeat (30) if (out_off !== 1'b1) @(negedge hclk);
		chk("off", 32'h1, out_off);
		loads(2);
		chk("off code", 32'h0, dac_code);
		@(posedge hclk);
		bus(1'b0, 8'h08, 32'h0, q);
		w = q[15:0];
		bus(1'b1, 8'h04, 32'h1, q);
		acks(1);
		@(negedge hclk);
		chk("off cleared", 32'h0, out_off);
		@(posedge hclk);
		bus(1'b0, 8'h08, 32'h0, q);
		chk("status", {15'h0, 1'b1, w + 16'h1}, q);
		summarize();
	end
endmodule
